// file: i2cm_divider.sv
// reload-based baud divider clocked by instruction-cycle enable
`timescale 1ns/100ps
`default_nettype none
module i2cm_divider #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic run,
  output logic timeout
);
  logic [W-1:0] cnt_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q <= '0;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (load) begin
        cnt_q <= load_val;
      end else if (run && tick) begin
        if (cnt_q == '0) begin
          timeout <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: i2cm_master.sv
// two-wire bus master sequencer with start timing and baud divider
`timescale 1ns/100ps
`default_nettype none
`include "i2cm_params.svh"
module i2cm_master (
  input wire logic CLOCK,
  input wire logic SRST,
  input wire logic ENABLE,
  input wire logic [7:0] RELOAD,
  input wire logic [4:0] CMD_WDATA,
  input wire logic CMD_WE,
  input wire logic [7:0] BUF_WDATA,
  input wire logic BUF_WE,
  input wire logic ACK_DATA,
  input wire logic IRQ_CLR,
  input wire logic BCOL_CLR,
  input wire logic WRITE_COLLISION_FLAG_CLR,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SCL_OUT,
  output logic SCL_OE,
  output logic SDA_OUT,
  output logic SDA_OE,
  output logic [4:0] CMD_BITS,
  output logic [7:0] RX_DATA,
  output logic ACK_STAT,
  output logic PORT_IRQ,
  output logic BUS_COLL,
  output logic WRITE_COLL,
  output logic START_SEEN,
  output logic STOP_SEEN,
  output logic BUF_FULL
);
  typedef struct packed {
    i2cm_pkg::i2cm_state_t st;
    logic [1:0] pre;
    logic [4:0] cmd;
    logic [7:0] sh;
    logic [3:0] bitn;
    logic rx;
    logic ackph;
    logic scl_lo;
    logic sda_lo;
    logic [7:0] rxd;
    logic acks;
    logic irq;
    logic bcol;
    logic write_collision_flag;
    logic ss;
    logic ps;
    logic bf;
  } i2cm_regs_t;

  i2cm_regs_t r_q, r_d;
  logic scl_s, sda_s, tick, timeout, dload, drun;
  logic [7:0] dval;

  i2cm_sync u_scl (.clk(CLOCK), .srst(SRST), .din(SCL_IN), .dout(scl_s));
  i2cm_sync u_sda (.clk(CLOCK), .srst(SRST), .din(SDA_IN), .dout(sda_s));
  i2cm_divider #(.W(8)) u_div (
    .clk(CLOCK), .srst(SRST), .tick(tick), .load(dload),
    .load_val(dval), .run(drun), .timeout(timeout)
  );

  assign tick = (r_q.pre == `I2CM_QUARTER);
  logic busy;
  assign busy = (r_q.st != i2cm_pkg::ST_IDLE);
  logic start_busy;
  assign start_busy = (r_q.st == i2cm_pkg::ST_S_WAIT) || (r_q.st == i2cm_pkg::ST_S_HOLD)
    || (r_q.st == i2cm_pkg::ST_RS_LO) || (r_q.st == i2cm_pkg::ST_RS_HI);

  always_comb begin
    r_d = r_q;
    dload = 1'b0;
    drun = 1'b0;
    dval = {1'b0, RELOAD[6:0]};
    r_d.pre = r_q.pre + 2'h1;
    if (IRQ_CLR) r_d.irq = 1'b0;
    if (BCOL_CLR) r_d.bcol = 1'b0;
    if (WRITE_COLLISION_FLAG_CLR) r_d.write_collision_flag = 1'b0;
    // software commands, accepted only when idle
    if (CMD_WE && !busy) begin
      r_d.cmd = CMD_WDATA;
    end
    if (BUF_WE) begin
      if (busy) begin
        r_d.write_collision_flag = 1'b1;
      end else begin
        r_d.sh = BUF_WDATA;
        r_d.bf = 1'b1;
        r_d.scl_lo = 1'b1;
        r_d.rx = 1'b0;
        r_d.bitn = 4'h0;
        r_d.ackph = 1'b0;
        r_d.st = i2cm_pkg::ST_BIT_LO;
        dload = 1'b1;
        dval = RELOAD;
      end
    end
    case (r_q.st)
      i2cm_pkg::ST_IDLE: begin
        if (r_q.cmd[`I2CM_CMD_START] && !BUF_WE) begin
          if (scl_s && sda_s) begin
            dload = 1'b1;
            r_d.st = i2cm_pkg::ST_S_WAIT;
          end else begin
            r_d.bcol = 1'b1;
            r_d.cmd[`I2CM_CMD_START] = 1'b0;
          end
        end else if (r_q.cmd[`I2CM_CMD_RSTART] && !BUF_WE) begin
          r_d.scl_lo = 1'b1;
          r_d.sda_lo = 1'b0;
          dload = 1'b1;
          r_d.st = i2cm_pkg::ST_RS_LO;
        end else if (r_q.cmd[`I2CM_CMD_STOP] && !BUF_WE) begin
          r_d.scl_lo = 1'b1;
          r_d.sda_lo = 1'b1;
          dload = 1'b1;
          r_d.st = i2cm_pkg::ST_P_LO;
        end else if (r_q.cmd[`I2CM_CMD_RECV] && !BUF_WE) begin
          r_d.rx = 1'b1;
          r_d.bitn = 4'h0;
          r_d.ackph = 1'b0;
          r_d.sda_lo = 1'b0;
          dload = 1'b1;
          r_d.st = i2cm_pkg::ST_BIT_LO;
        end else if (r_q.cmd[`I2CM_CMD_ACK] && !BUF_WE) begin
          r_d.rx = 1'b1;
          r_d.ackph = 1'b1;
          r_d.sda_lo = ~ACK_DATA;
          dload = 1'b1;
          r_d.st = i2cm_pkg::ST_BIT_LO;
        end
      end
      i2cm_pkg::ST_S_WAIT: begin
        drun = 1'b1;
        if (!scl_s) begin
          r_d.bcol = 1'b1;
          r_d.cmd[`I2CM_CMD_START] = 1'b0;
          r_d.st = i2cm_pkg::ST_IDLE;
        end else if (timeout) begin
          if (sda_s) begin
            r_d.sda_lo = 1'b1;
            r_d.ss = 1'b1;
            r_d.ps = 1'b0;
            dload = 1'b1;
            dval = RELOAD;
            r_d.st = i2cm_pkg::ST_S_HOLD;
          end else begin
            r_d.bcol = 1'b1;
            r_d.cmd[`I2CM_CMD_START] = 1'b0;
            r_d.st = i2cm_pkg::ST_IDLE;
          end
        end
      end
      i2cm_pkg::ST_S_HOLD: begin
        drun = 1'b1;
        if (timeout) begin
          r_d.cmd[`I2CM_CMD_START] = 1'b0;
          r_d.scl_lo = 1'b0;
          r_d.irq = 1'b1;
          r_d.st = i2cm_pkg::ST_IDLE;
        end
      end
      i2cm_pkg::ST_RS_LO: begin
        drun = 1'b1;
        if (timeout) begin
          r_d.scl_lo = 1'b0;
          r_d.st = i2cm_pkg::ST_RS_HI;
        end
      end
      i2cm_pkg::ST_RS_HI: begin
        if (!scl_s) begin
          dload = 1'b1;
        end else begin
          drun = 1'b1;
          if (timeout) begin
            r_d.sda_lo = 1'b1;
            r_d.ss = 1'b1;
            dload = 1'b1;
            dval = RELOAD;
            r_d.st = i2cm_pkg::ST_S_HOLD;
            r_d.cmd[`I2CM_CMD_RSTART] = 1'b0;
            r_d.cmd[`I2CM_CMD_START] = 1'b1;
          end
        end
      end
      i2cm_pkg::ST_BIT_LO: begin
        // clock low half: set the data line, then release clock
        r_d.scl_lo = 1'b1;
        drun = 1'b1;
        if (!r_q.rx && !r_q.ackph) begin
          r_d.sda_lo = (r_q.bitn == 4'h8) ? 1'b0 : ~r_q.sh[7];
        end else if (r_q.rx && !r_q.ackph) begin
          r_d.sda_lo = 1'b0;
        end
        if (timeout) begin
          r_d.scl_lo = 1'b0;
          r_d.st = i2cm_pkg::ST_BIT_HI;
        end
      end
      i2cm_pkg::ST_BIT_HI: begin
        if (!scl_s) begin
          dload = 1'b1;
        end else begin
          drun = 1'b1;
          if (timeout) begin
            r_d.scl_lo = 1'b1;
            dload = 1'b1;
            dval = RELOAD;
            r_d.st = i2cm_pkg::ST_BIT_LO;
            if (r_q.ackph) begin
              r_d.sda_lo = 1'b0;
              r_d.cmd[`I2CM_CMD_ACK] = 1'b0;
              r_d.irq = 1'b1;
              r_d.st = i2cm_pkg::ST_IDLE;
            end else if (r_q.rx) begin
              r_d.rxd = {r_q.rxd[6:0], sda_s};
              r_d.bitn = r_q.bitn + 4'h1;
              if (r_q.bitn == 4'h7) begin
                r_d.cmd[`I2CM_CMD_RECV] = 1'b0;
                r_d.bf = 1'b1;
                r_d.irq = 1'b1;
                r_d.st = i2cm_pkg::ST_IDLE;
              end
            end else if (r_q.bitn == 4'h8) begin
              r_d.acks = sda_s;
              r_d.irq = 1'b1;
              r_d.st = i2cm_pkg::ST_IDLE;
            end else begin
              r_d.sh = {r_q.sh[6:0], 1'b0};
              r_d.bitn = r_q.bitn + 4'h1;
              if (r_q.bitn == 4'h7) r_d.bf = 1'b0;
            end
          end
        end
      end
      i2cm_pkg::ST_P_LO: begin
        drun = 1'b1;
        if (timeout) begin
          r_d.scl_lo = 1'b0;
          r_d.st = i2cm_pkg::ST_P_HI;
        end
      end
      i2cm_pkg::ST_P_HI: begin
        if (!scl_s) begin
          dload = 1'b1;
        end else begin
          drun = 1'b1;
          if (timeout) begin
            r_d.sda_lo = 1'b0;
            dload = 1'b1;
            r_d.st = i2cm_pkg::ST_P_END;
          end
        end
      end
      i2cm_pkg::ST_P_END: begin
        drun = 1'b1;
        if (timeout) begin
          r_d.cmd[`I2CM_CMD_STOP] = 1'b0;
          r_d.ps = 1'b1;
          r_d.ss = 1'b0;
          r_d.irq = 1'b1;
          r_d.st = i2cm_pkg::ST_IDLE;
        end
      end
      default: r_d.st = i2cm_pkg::ST_IDLE;
    endcase
    if (!ENABLE) begin
      r_d.ss = 1'b0;
      r_d.ps = 1'b0;
      r_d.st = i2cm_pkg::ST_IDLE;
      r_d.cmd = 5'h00;
      r_d.scl_lo = 1'b0;
      r_d.sda_lo = 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      r_q <= '{st: i2cm_pkg::ST_IDLE, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  always_comb begin
    SCL_OUT = 1'b0;
    SCL_OE = r_q.scl_lo;
    SDA_OUT = 1'b0;
    SDA_OE = r_q.sda_lo;
    CMD_BITS = r_q.cmd;
    RX_DATA = r_q.rxd;
    ACK_STAT = r_q.acks;
    PORT_IRQ = r_q.irq;
    BUS_COLL = r_q.bcol;
    WRITE_COLL = r_q.write_collision_flag;
    START_SEEN = r_q.ss;
    STOP_SEEN = r_q.ps;
    BUF_FULL = r_q.bf;
  end

  a_write_collision_flag_on_busy: assert property (@(posedge CLOCK) disable iff (SRST)
    (BUF_WE && busy && ENABLE) |=> WRITE_COLL)
    else $error("write during busy did not set collision");
  a_start_sda_low: assert property (@(posedge CLOCK) disable iff (SRST)
    (r_q.st == i2cm_pkg::ST_S_HOLD) |-> SDA_OE)
    else $error("data not held low in start hold");
  a_start_done: assert property (@(posedge CLOCK) disable iff (SRST)
    (r_q.st == i2cm_pkg::ST_S_HOLD && timeout && ENABLE) |=> !CMD_BITS[0] && PORT_IRQ)
    else $error("start did not complete");
  a_cmd_locked: assert property (@(posedge CLOCK) disable iff (SRST)
    (start_busy && ENABLE && !timeout) |=> $stable(CMD_BITS[4:1]))
    else $error("commands changed during start");
  a_disable_clr: assert property (@(posedge CLOCK) disable iff (SRST)
    !ENABLE |=> !START_SEEN && !STOP_SEEN)
    else $error("status not cleared by disable");
  a_tick_rate: assert property (@(posedge CLOCK) disable iff (SRST)
    tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
    else $error("instruction tick spacing wrong");
  a_buf_start: assert property (@(posedge CLOCK) disable iff (SRST)
    (BUF_WE && !busy && ENABLE) |=> r_q.st == i2cm_pkg::ST_BIT_LO)
    else $error("buffer write did not start divider");
  a_coll_abort: assert property (@(posedge CLOCK) disable iff (SRST)
    (r_q.st == i2cm_pkg::ST_S_WAIT && !scl_s && ENABLE) |=> BUS_COLL && !busy)
    else $error("collision did not abort start");
endmodule
`default_nettype wire

// file: i2cm_params.svh
// constants, rule overview and field positions for the two-wire master
//
// Overview of operation
// - master makes every clock pulse plus start and stop conditions itself
// - transfer ends with stop or repeated start; bus kept after repeated start
// - transmit sends 7-bit address with direction zero, bytes, takes ack each
// - receive sends address with direction one, clocks bytes in, drives ack
// - after eight bits, slave ack sampled into ack_received_flag
// - end of ninth clock of transmitted byte sets port_irq_flag
// - start request sets port_irq_flag after start hold time elapses
// - stop request bit; interrupt only once stop fully completed
// - divider reloads from address_reload_reg; buffer write starts counting
// - divider stops after last bit and ack; clock line keeps level
// - clock rate is oscillator over four times reload plus one; here each clock half alone lasts four times reload plus one
// - released clock pauses divider until sampled high, reload low seven bits
// - start request with both lines high reloads low seven bits, counts
// - timeout with both lines high drives data low, sets start detected
// - after start edge reload eight bits; timeout clears request, holds low
// - lines low at onset or clock low early: collision, abort, idle
// - buffer write during start is dropped and sets write_collision_flag
// - low five command bits ignored until start completes
// - irq also on stop, each byte, ack sent, repeated start done
// - start and stop detected bits cleared by reset or disable
`ifndef I2CM_PARAMS_SVH
`define I2CM_PARAMS_SVH
`define I2CM_CMD_START 0
`define I2CM_CMD_RSTART 1
`define I2CM_CMD_STOP 2
`define I2CM_CMD_RECV 3
`define I2CM_CMD_ACK 4
`define I2CM_RELOAD_RST 8'h00
`define I2CM_QUARTER 2'h3
`endif

// file: i2cm_pkg.sv
// types for the two-wire master
package i2cm_pkg;
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_S_WAIT = 10'h002,
    ST_S_HOLD = 10'h004,
    ST_BIT_LO = 10'h008,
    ST_BIT_HI = 10'h010,
    ST_RS_LO = 10'h020,
    ST_RS_HI = 10'h040,
    ST_P_LO = 10'h080,
    ST_P_HI = 10'h100,
    ST_P_END = 10'h200
  } i2cm_state_t;
endpackage

// file: i2cm_slave_model.sv
// open-drain bus lines with a behavioural slave that acks, nacks and stretches
`timescale 1ns/100ps
`default_nettype none
module i2cm_slave_model (
  input wire logic clk,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic nack,
  input wire logic stretch,
  input wire logic hold_low,
  output logic scl,
  output logic sda,
  output logic [7:0] got_byte
);
  logic scl_low_q = 1'b0;
  logic sda_low_q = 1'b0;
  int bits = 0;
  // pull-ups: a released line reads high
  assign scl = ~(scl_oe | scl_low_q | hold_low);
  assign sda = ~(sda_oe | sda_low_q | hold_low);
  always @(negedge sda) begin
    if (scl === 1'b1) bits = 0;
  end
  always @(posedge scl) begin
    if (bits < 8) got_byte = {got_byte[6:0], sda};
    bits = bits + 1;
  end
  always @(negedge scl) begin
    sda_low_q = (bits == 8) && !nack;
    if (bits == 9) bits = 0;
    if (stretch) begin
      scl_low_q = 1'b1;
      repeat (30) @(posedge clk);
      scl_low_q = 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: i2cm_sync.sv
// two-flop synchroniser for one pin level
`timescale 1ns/100ps
`default_nettype none
module i2cm_sync (
  input wire logic clk,
  input wire logic srst,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      meta_q <= 1'b1;
      dout <= 1'b1;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule
`default_nettype wire

// file: tb_i2c_master_start_and_baud.sv
// self-checking bench for start timing, transmit and collision paths
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_master_start_and_baud;
  typedef struct {logic [7:0] rl; int e1; int e2;} i2cm_row_t;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic enable = 1'b1;
  logic [7:0] reload = 8'h02;
  logic [4:0] cmd_wdata = 5'h00;
  logic [7:0] buf_wdata = 8'h00;
  logic cmd_we = 1'b0;
  logic buf_we = 1'b0;
  logic ack_data = 1'b0;
  logic irq_clr = 1'b0;
  logic bcol_clr = 1'b0;
  logic write_collision_flag_clr = 1'b0;
  logic nack = 1'b0;
  logic stretch = 1'b0;
  logic hold_low = 1'b0;
  logic scl, sda, scl_oe, sda_oe, scl_o, sda_o, ack_stat, port_irq;
  logic bus_coll, write_coll, start_seen, stop_seen, buf_full;
  logic [4:0] cmd_bits;
  logic [7:0] rx_data, got_byte;
  logic [2:0] watch;
  int fail_count = 0;
  int checks_done = 0;
  int t1, t2;
  i2cm_row_t rows [3] = '{'{8'h02, 12, 12}, '{8'h05, 24, 24}, '{8'h81, 8, 520}};
  assign watch = {bus_coll, sda_oe, port_irq};
  always #20 clk = ~clk;
  i2cm_master u_dut (.CLOCK(clk), .SRST(srst), .ENABLE(enable), .RELOAD(reload),
    .CMD_WDATA(cmd_wdata), .CMD_WE(cmd_we), .BUF_WDATA(buf_wdata), .BUF_WE(buf_we),
    .ACK_DATA(ack_data), .IRQ_CLR(irq_clr), .BCOL_CLR(bcol_clr), .WRITE_COLLISION_FLAG_CLR(write_collision_flag_clr),
    .SCL_IN(scl), .SDA_IN(sda), .SCL_OUT(scl_o), .SCL_OE(scl_oe), .SDA_OUT(sda_o),
    .SDA_OE(sda_oe), .CMD_BITS(cmd_bits), .RX_DATA(rx_data), .ACK_STAT(ack_stat),
    .PORT_IRQ(port_irq), .BUS_COLL(bus_coll), .WRITE_COLL(write_coll),
    .START_SEEN(start_seen), .STOP_SEEN(stop_seen), .BUF_FULL(buf_full));
  i2cm_slave_model u_slave (.clk(clk), .scl_oe(scl_oe), .sda_oe(sda_oe), .nack(nack),
    .stretch(stretch), .hold_low(hold_low), .scl(scl), .sda(sda), .got_byte(got_byte));
  task automatic test_done;
    if (fail_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  // strobes: {write_collision_flag_clr, bcol_clr, irq_clr, buf_we, cmd_we}
  task automatic go(input logic [4:0] w);
    {write_collision_flag_clr, bcol_clr, irq_clr, buf_we, cmd_we} <= w;
    @(posedge clk);
    {write_collision_flag_clr, bcol_clr, irq_clr, buf_we, cmd_we} <= 5'h00;
    @(posedge clk);
  endtask
  task automatic wait_hi(input int k, input int lim, output int n);
    n = 0;
    while (watch[k] !== 1'b1) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        fail_count++;
        test_done();
      end
    end
  endtask
  task automatic start_seq;
    cmd_wdata <= 5'h01;
    go(5'h01);
    wait_hi(0, 3000, t1);
    go(5'h04);
  endtask
  task automatic stop_seq;
    cmd_wdata <= 5'h04;
    go(5'h05);
    wait_hi(0, 3000, t2);
    chk("stop done", 3'h4, {stop_seen, sda_oe, scl_oe});
    go(5'h04);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("reset state", 8'h00, {port_irq, bus_coll, write_coll, start_seen, sda_oe, scl_oe});
    chk("reset cmd", 5'h00, cmd_bits);
    foreach (rows[i]) begin
      reload <= rows[i].rl;
      cmd_wdata <= 5'h01;
      go(5'h01);
      chk("start pending", 5'h01, cmd_bits);
      wait_hi(1, 3000, t1);
      chk("start edge time", 1, t1 + 4 >= rows[i].e1 && t1 <= rows[i].e1 + 8);
      chk("clock high at start", 0, scl_oe);
      wait_hi(0, 3000, t2);
      chk("start hold time", 1, t2 + 4 >= rows[i].e2 && t2 <= rows[i].e2 + 8);
      chk("start done", 4'hC, {start_seen, sda_oe, scl_oe, cmd_bits[0]});
      stop_seq();
    end
    reload <= 8'h02;
    start_seq();
    buf_wdata <= 8'hA4;
    go(5'h02);
    wait_hi(0, 3000, t1);
    chk("address byte", 8'hA4, got_byte);
    chk("ack and clock low", 2'h2, {scl_oe, ack_stat});
    chk("buf empty", 1'b0, buf_full);
    chk("open drain", 2'h0, {scl_o, sda_o});
    go(5'h04);
    nack <= 1'b1;
    stretch <= 1'b1;
    buf_wdata <= 8'h3C;
    go(5'h02);
    wait_hi(0, 5000, t1);
    chk("stretched byte", 8'h3C, got_byte);
    chk("stretch time", 1, t1 > 300);
    chk("nack", 1'b1, ack_stat);
    go(5'h04);
    nack <= 1'b0;
    stretch <= 1'b0;
    stop_seq();
    cmd_wdata <= 5'h01;
    go(5'h01);
    buf_wdata <= 8'h55;
    cmd_wdata <= 5'h04;
    go(5'h03);
    chk("write collision", 2'h3, {write_coll, cmd_bits[0]});
    chk("command lock", 1'b0, cmd_bits[2]);
    wait_hi(0, 3000, t1);
    go(5'h14);
    chk("write_collision_flag clear", 2'h0, {write_coll, port_irq});
    enable <= 1'b0;
    repeat (2) @(posedge clk);
    chk("seen cleared", 2'h0, {start_seen, stop_seen});
    enable <= 1'b1;
    hold_low <= 1'b1;
    repeat (4) @(posedge clk);
    cmd_wdata <= 5'h01;
    go(5'h01);
    wait_hi(2, 200, t1);
    go(5'h00);
    chk("collision abort", 2'h0, {sda_oe, cmd_bits[0]});
    go(5'h08);
    chk("collision clear", 1'b0, bus_coll);
    hold_low <= 1'b0;
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire
